//--- mcsw_pkg.sv
package mcsw_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 8;
    localparam int CLK_PERIOD_SHIFT = $clog2(CLK_PERIOD_NS);

    // Card geometry.
    localparam int JOINTS = 6;
    localparam int ESTOPS = 2;
    localparam int NODE_ID_W = 4;
    localparam int NODES = 1 << NODE_ID_W;
    localparam int SW_W = 3 * JOINTS + ESTOPS;

    // Register byte offsets.
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_TIMEOUT = 6'h04;
    localparam logic [5:0] OFS_STATUS = 6'h08;
    localparam logic [5:0] OFS_INPUTS = 6'h0C;
    localparam logic [5:0] OFS_INPUTS_N = 6'h10;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h14;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h18;
    localparam logic [5:0] OFS_NODES = 6'h1C;

    // Control register fields.
    localparam int CTRL_WD_EN = 0;
    localparam int CTRL_PWR_REQ = 1;
    localparam int CTRL_HOST_RUN = 2;
    localparam int CTRL_RESCAN = 3;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // Status register fields.
    localparam int ST_WD_EXP = 0;
    localparam int ST_PWR_EN = 1;
    localparam int ST_PWR_FAULT = 2;
    localparam int ST_BUS_SCAN = 3;
    localparam int ST_BUS_DROP = 4;

    // Input register layout: origin, lower, upper per joint, then e-stops.
    localparam int IN_ORIGIN = 0;
    localparam int IN_LOWER = JOINTS;
    localparam int IN_UPPER = 2 * JOINTS;
    localparam int IN_ESTOP = 3 * JOINTS;

    // Interrupt status and mask fields.
    localparam int IRQ_WD_EXP = 0;
    localparam int IRQ_PWR_FAULT = 1;
    localparam int IRQ_NODE_DROP = 2;
    localparam int IRQ_ESTOP = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Host timeout in ns after reset: three 1 ms servo periods.
    localparam logic [31:0] TIMEOUT_RST_NS = 32'h002D_C6C0;

    // Node supervision and indicator timing.
    localparam int MISS_LIMIT = 3;
    localparam int BLINK_HALF_NS = 250_000_000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int CAN_HOLD_TICKS = 2;

    typedef enum logic [3:0] {
        BUS_SCAN_ISSUE = 4'b0001,
        BUS_SCAN_WAIT = 4'b0010,
        BUS_RUN_ISSUE = 4'b0100,
        BUS_RUN_WAIT = 4'b1000
    } mcsw_bus_t;

endpackage

//--- mcsw_blink.sv
`timescale 1ns/1ps
module mcsw_blink
#(
    parameter int HALF_CYC = 31_250_000
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Blink timing.
    output logic tick,
    output logic blink
);

    localparam int CNT_W = $clog2(HALF_CYC + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

    logic [CNT_W-1:0] cnt_q;
    logic blink_q;
    logic wrap;

    initial
    begin
        if (HALF_CYC < 1)
            $error("HALF_CYC must be at least one cycle.");
    end

    assign wrap = (cnt_q == LAST);
    assign tick = wrap;
    assign blink = blink_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else
        begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            blink_q <= blink_q ^ wrap;
        end
    end

endmodule

//--- mcsw_watchdog.sv
`timescale 1ns/1ps
// Contract
// - Host input read restarts the watchdog; only a read at OFS_INPUTS does, not at OFS_INPUTS_N.
// - Expiry drops power enable in hardware.
// - Expired flag readable by the host.
// - Watchdog counts only while enabled.
// - Power enable needs request, no expiry, no fault.
// - Error LED: off, blink PCI error, on expired.
// - CAN LED: blink traffic, on full, else off.
// - RS485 LED: blink scan, on ok, off drop.
// - Host LED blinks while control software runs.
// - Boot LED lit once booting completed.
// - Six joints: origin, two limits, true and inverted.
// - Two e-stops presented true and inverted.
// - Nodes carry unique four-bit addresses.
// - Card discovers chain nodes by itself.
// - Silent nodes leave the active set.
module mcsw_watchdog
    import mcsw_pkg::*;
#(
    parameter int BLINK_CYC = mcsw_pkg::BLINK_HALF_CYC
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave.
    input wire logic [mcsw_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt.
    output logic irq,
    // Switch and power fault pins.
    input wire logic [mcsw_pkg::JOINTS-1:0] jointOriginSwitch,
    input wire logic [mcsw_pkg::JOINTS-1:0] jointLowerLimitSwitch,
    input wire logic [mcsw_pkg::JOINTS-1:0] jointUpperLimitSwitch,
    input wire logic [mcsw_pkg::ESTOPS-1:0] estopSwitch,
    input wire logic powerFault,
    // Shared power enable of axis and CAN connectors.
    output logic powerEnable,
    // Card state from neighbouring logic.
    input wire logic bootDone,
    input wire logic pciCommError,
    input wire logic canFrame,
    input wire logic canBufferFull,
    // RS485 poll engine.
    output logic pollReq,
    output logic [mcsw_pkg::NODE_ID_W-1:0] pollId,
    input wire logic pollAnswer,
    input wire logic pollNoAnswer,
    // Status indicators.
    output logic ledCan,
    output logic ledRs485,
    output logic host_activity_led,
    output logic ledBoot,
    output logic ledError
);
    import mcsw_pkg::*;

    initial
    begin
        if (CLK_PERIOD_NS != (1 << CLK_PERIOD_SHIFT))
            $error("Clock period must be a power of two in ns.");
    end

    // Bus slave: one wait cycle per access, then the access completes.
    logic ack_q;
    logic [31:0] readdata_q;
    logic access, accept, rdAccept, wrAccept;
    logic [31:0] rdMux, beMask;
    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_q;
    assign accept = access & ack_q;
    assign rdAccept = avs_read & ack_q;
    assign wrAccept = avs_write & ack_q;
    assign avs_readdata = readdata_q;
    assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    logic [5:0] wordAddr;
    assign wordAddr = {avs_address[5:2], 2'b00};
    logic wrCtrl, wrTimeout, wrMask, rdInputs, rdIrq;
    assign wrCtrl = wrAccept & (wordAddr == OFS_CTRL);
    assign wrTimeout = wrAccept & (wordAddr == OFS_TIMEOUT);
    assign wrMask = wrAccept & (wordAddr == OFS_IRQ_MASK);
    assign rdInputs = rdAccept & (wordAddr == OFS_INPUTS);
    assign rdIrq = rdAccept & (wordAddr == OFS_IRQ_STAT);

    // Software registers.
    logic [CTRL_W-1:0] ctrl_q;
    logic [31:0] timeout_q, timeoutNew;
    logic [IRQ_W-1:0] irqMask_q, irqStat_q, irqEvt;
    logic rescan;
    logic wdEn, pwrReq, hostRun;
    assign wdEn = ctrl_q[CTRL_WD_EN];
    assign pwrReq = ctrl_q[CTRL_PWR_REQ];
    assign hostRun = ctrl_q[CTRL_HOST_RUN];
    assign rescan = wrCtrl & avs_byteenable[0] & avs_writedata[CTRL_RESCAN];
    assign timeoutNew = (timeout_q & ~beMask) | (avs_writedata & beMask);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ctrl_q <= CTRL_RST;
            timeout_q <= TIMEOUT_RST_NS;
            irqMask_q <= IRQ_MASK_RST;
        end
        else
        begin
            if (wrCtrl && avs_byteenable[0])
                ctrl_q <= avs_writedata[CTRL_W-1:0];
            if (wrTimeout)
                timeout_q <= timeoutNew;
            if (wrMask && avs_byteenable[0])
                irqMask_q <= avs_writedata[IRQ_W-1:0];
        end
    end

    // Switch and fault pins pass two flip-flops.
    logic [SW_W-1:0] swMeta_q, sw_q, swRaw;
    logic faultMeta_q, fault_q, faultPrev_q;
    logic [ESTOPS-1:0] estopPrev_q;
    assign swRaw = {estopSwitch, jointUpperLimitSwitch,
                    jointLowerLimitSwitch, jointOriginSwitch};

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            swMeta_q <= '0;
            sw_q <= '0;
            faultMeta_q <= 1'b0;
            fault_q <= 1'b0;
            faultPrev_q <= 1'b0;
            estopPrev_q <= '0;
        end
        else
        begin
            swMeta_q <= swRaw;
            sw_q <= swMeta_q;
            faultMeta_q <= powerFault;
            fault_q <= faultMeta_q;
            faultPrev_q <= fault_q;
            estopPrev_q <= sw_q[IN_ESTOP +: ESTOPS];
        end
    end

    // Watchdog. The timeout is held in ns; a shift turns it into cycles,
    // which is why the clock period must be a power of two.
    logic [31:0] wdCnt_q, timeoutCyc;
    logic wdExpired_q, wdEnPrev_q;
    logic wdEnRise, wdExpireEvt;
    assign timeoutCyc = timeout_q >> CLK_PERIOD_SHIFT;
    assign wdEnRise = wdEn & ~wdEnPrev_q;
    assign wdExpireEvt = wdEn & ~wdEnRise & ~rdInputs & ~wdExpired_q
                         & (wdCnt_q >= timeoutCyc);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wdCnt_q <= '0;
            wdExpired_q <= 1'b0;
            wdEnPrev_q <= 1'b0;
        end
        else
        begin
            wdEnPrev_q <= wdEn;
            if (!wdEn || wdEnRise || rdInputs)
                wdCnt_q <= '0;
            else if (!wdExpired_q)
                wdCnt_q <= wdCnt_q + 32'h0000_0001;
            if (wdEnRise)
                wdExpired_q <= 1'b0;
            else if (wdExpireEvt)
                wdExpired_q <= 1'b1;
        end
    end

    // Power enable falls in the cycle after expiry, with no host action.
    logic powerEnable_q;
    always_ff @(posedge clk)
    begin
        if (!resetn)
            powerEnable_q <= 1'b0;
        else
            powerEnable_q <= pwrReq & ~wdExpired_q & ~wdExpireEvt
                             & ~fault_q;
    end
    assign powerEnable = powerEnable_q;

    // RS485 chain supervision: one sweep of all addresses discovers the
    // nodes, then polling goes round; new nodes only join on a rescan.
    mcsw_bus_t busState_q;
    logic [NODE_ID_W-1:0] pollId_q;
    logic pollReq_q, busDrop_q;
    logic [NODES-1:0] nodeActive_q, nodeDrop;
    logic [1:0] missCnt_q [NODES];
    logic pollDone, scanning, lastId;
    assign pollDone = pollAnswer | pollNoAnswer;
    assign scanning = (busState_q == BUS_SCAN_ISSUE)
                      | (busState_q == BUS_SCAN_WAIT);
    assign lastId = (pollId_q == NODE_ID_W'(NODES - 1));

    always_ff @(posedge clk)
    begin
        if (!resetn || rescan)
        begin
            busState_q <= BUS_SCAN_ISSUE;
            pollId_q <= '0;
            pollReq_q <= 1'b0;
        end
        else
        begin
            case (busState_q)
                BUS_SCAN_ISSUE, BUS_RUN_ISSUE:
                begin
                    pollReq_q <= 1'b1;
                    busState_q <= (busState_q == BUS_SCAN_ISSUE)
                                  ? BUS_SCAN_WAIT : BUS_RUN_WAIT;
                end
                BUS_SCAN_WAIT, BUS_RUN_WAIT:
                    if (pollDone)
                    begin
                        pollReq_q <= 1'b0;
                        pollId_q <= pollId_q + 1'b1;
                        busState_q <= BUS_RUN_ISSUE;
                        if (busState_q == BUS_SCAN_WAIT && !lastId)
                            busState_q <= BUS_SCAN_ISSUE;
                    end
                default:
                    busState_q <= BUS_SCAN_ISSUE;
            endcase
        end
    end
    assign pollReq = pollReq_q;
    assign pollId = pollId_q;

    genvar g;
    generate
        for (g = 0; g < NODES; g++)
        begin : gNode
            logic hit;
            assign hit = (pollId_q == NODE_ID_W'(g))
                         & ((busState_q == BUS_SCAN_WAIT)
                         | (busState_q == BUS_RUN_WAIT));
            assign nodeDrop[g] = hit & pollNoAnswer & nodeActive_q[g]
                                 & (busState_q == BUS_RUN_WAIT)
                                 & (missCnt_q[g] == 2'(MISS_LIMIT - 1));
            always_ff @(posedge clk)
            begin
                if (!resetn || rescan)
                begin
                    nodeActive_q[g] <= 1'b0;
                    missCnt_q[g] <= '0;
                end
                else if (hit && pollAnswer)
                begin
                    missCnt_q[g] <= '0;
                    if (busState_q == BUS_SCAN_WAIT)
                        nodeActive_q[g] <= 1'b1;
                end
                else if (nodeDrop[g])
                begin
                    nodeActive_q[g] <= 1'b0;
                    missCnt_q[g] <= '0;
                end
                else if (hit && pollNoAnswer && nodeActive_q[g])
                    missCnt_q[g] <= missCnt_q[g] + 2'h1;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!resetn || rescan)
            busDrop_q <= 1'b0;
        else if (|nodeDrop)
            busDrop_q <= 1'b1;
    end

    // Interrupts: a read clears only the bits that it returned, so an
    // event landing between capture and completion is not lost.
    logic [IRQ_W-1:0] irqClear;
    assign irqClear = rdIrq ? readdata_q[IRQ_W-1:0] : '0;
    assign irqEvt[IRQ_WD_EXP] = wdExpireEvt;
    assign irqEvt[IRQ_PWR_FAULT] = fault_q & ~faultPrev_q;
    assign irqEvt[IRQ_NODE_DROP] = |nodeDrop;
    assign irqEvt[IRQ_ESTOP] = |(sw_q[IN_ESTOP +: ESTOPS] ^ estopPrev_q);

    always_ff @(posedge clk)
    begin
        if (!resetn)
            irqStat_q <= '0;
        else
            irqStat_q <= (irqStat_q & ~irqClear) | irqEvt;
    end
    assign irq = |(irqStat_q & irqMask_q);

    // Read data are captured in the wait cycle and stand at completion.
    logic [31:0] statusWord;
    assign statusWord = {27'h0, busDrop_q, scanning, fault_q,
                         powerEnable_q, wdExpired_q};
    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (wordAddr)
            OFS_CTRL: rdMux = {29'h0, ctrl_q};
            OFS_TIMEOUT: rdMux = timeout_q;
            OFS_STATUS: rdMux = statusWord;
            OFS_INPUTS: rdMux = {12'h0, sw_q};
            OFS_INPUTS_N: rdMux = {12'h0, ~sw_q};
            OFS_IRQ_STAT: rdMux = {28'h0, irqStat_q};
            OFS_IRQ_MASK: rdMux = {28'h0, irqMask_q};
            OFS_NODES: rdMux = {16'h0, nodeActive_q};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
            readdata_q <= '0;
        end
        else
        begin
            ack_q <= access & ~ack_q;
            if (avs_read && !ack_q)
                readdata_q <= rdMux;
        end
    end

    // Indicators. CAN activity is held until the second blink tick after
    // the last frame so that sparse traffic still shows as blinking.
    logic tick, blink;
    mcsw_blink #(.HALF_CYC(BLINK_CYC)) uBlink
    (
        .clk(clk),
        .resetn(resetn),
        .tick(tick),
        .blink(blink)
    );

    logic [1:0] canAge_q;
    logic canAct;
    assign canAct = (canAge_q != 2'h0);
    always_ff @(posedge clk)
    begin
        if (!resetn)
            canAge_q <= 2'h0;
        else if (canFrame)
            canAge_q <= 2'(CAN_HOLD_TICKS);
        else if (tick && canAct)
            canAge_q <= canAge_q - 2'h1;
    end

    logic ledCan_q, ledRs485_q, ledHost_q, ledBoot_q, ledError_q;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ledCan_q <= 1'b0;
            ledRs485_q <= 1'b0;
            ledHost_q <= 1'b0;
            ledBoot_q <= 1'b0;
            ledError_q <= 1'b0;
        end
        else
        begin
            ledCan_q <= canBufferFull | (canAct & blink);
            ledRs485_q <= scanning ? blink : ~busDrop_q;
            ledHost_q <= hostRun & blink;
            ledBoot_q <= bootDone;
            ledError_q <= wdExpired_q | (pciCommError & blink);
        end
    end
    assign ledCan = ledCan_q;
    assign ledRs485 = ledRs485_q;
    assign host_activity_led = ledHost_q;
    assign ledBoot = ledBoot_q;
    assign ledError = ledError_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_wd_restart: assert property (rdInputs && wdEn && !wdEnRise
        |=> wdCnt_q == 32'h0 ##1 (wdCnt_q == 32'h1 || wdExpired_q
            || !wdEn || rdInputs))
        else $error("Input read did not restart the watchdog.");
    chk_power_drop: assert property (wdExpireEvt
        |=> wdExpired_q && !powerEnable ##1 !powerEnable)
        else $error("Power enable stayed high after expiry.");
    chk_expired_flag: assert property (wdExpireEvt
        |=> statusWord[ST_WD_EXP] && irqStat_q[IRQ_WD_EXP])
        else $error("Expiry not shown in status.");
    chk_wd_idle: assert property (!wdEn |=> !$rose(wdExpired_q))
        else $error("Watchdog expired while disabled.");
    chk_power_gate: assert property (powerEnable
        |-> $past(pwrReq) && !$past(wdExpired_q) && !$past(fault_q))
        else $error("Power enable without all conditions.");
    chk_error_led: assert property (wdExpired_q [*2] |-> ledError)
        else $error("Error LED not steady after expiry.");
    chk_can_led: assert property ($past(canBufferFull) |-> ledCan)
        else $error("CAN LED not steady on full buffer.");
    chk_bus_led: assert property (!scanning && busDrop_q
        |=> !ledRs485)
        else $error("RS485 LED lit after node drop.");
    chk_host_led: assert property (!hostRun [*2]
        |-> !host_activity_led)
        else $error("Host LED lit while host idle.");
    chk_boot_led: assert property (ledBoot == $past(bootDone))
        else $error("Boot LED does not follow boot state.");
    chk_node_drop: assert property (nodeDrop[pollId_q] && !rescan
        |=> !nodeActive_q[$past(pollId_q)] && busDrop_q)
        else $error("Dropped node still active.");
    chk_expiry_hold: assert property (wdExpired_q && !wdEnRise
        |=> wdExpired_q)
        else $error("Expired flag released without re-enable.");

    cov_expiry: cover property (wdExpireEvt ##1 !powerEnable);
    cov_drop: cover property (|nodeDrop);
    cov_scan_done: cover property (busState_q == BUS_SCAN_WAIT && lastId
        && pollDone);
    cov_irq: cover property ($rose(irq));

endmodule

//--- mcsw_node_model.sv
`timescale 1ns/1ps
module mcsw_node_model
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Fitted nodes and answer delay in cycles.
    input wire logic [15:0] present,
    input wire logic [3:0] ansDelay,
    // Poll link.
    input wire logic pollReq,
    input wire logic [3:0] pollId,
    output logic pollAnswer,
    output logic pollNoAnswer,
    // Error state of the output nodes.
    output logic nodeError
);
    logic [3:0] waitCnt_q;
    logic done_q;
    logic [7:0] starve_q;

    // Output nodes fall into their error state when polling stops for a
    // long spell; a poll of any address refreshes the whole chain.
    assign nodeError = (starve_q == 8'hFF);
    always_ff @(posedge clk)
    begin
        if (!resetn || pollReq)
            starve_q <= 8'h00;
        else if (starve_q != 8'hFF)
            starve_q <= starve_q + 8'h01;
    end

    // One done pulse per poll; a second pulse would end the next poll early.
    always_ff @(posedge clk)
    begin
        pollAnswer <= 1'h0;
        pollNoAnswer <= 1'h0;
        if (!resetn || !pollReq)
        begin
            waitCnt_q <= 4'h0;
            done_q <= 1'h0;
        end
        else if (!done_q && waitCnt_q >= ansDelay)
        begin
            pollAnswer <= present[pollId];
            pollNoAnswer <= !present[pollId];
            done_q <= 1'h1;
        end
        else
            waitCnt_q <= waitCnt_q + 4'h1;
    end
endmodule

//--- motion_card_safety_watchdog_bench.sv
`timescale 1ns/1ps
module motion_card_safety_watchdog_bench;
    import mcsw_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic [5:0] busAddr = 6'h00;
    logic busRead = 1'h0;
    logic busWrite = 1'h0;
    logic [31:0] busWdata = 32'h0;
    logic [31:0] busRdata;
    logic busWait, irq, powerEnable, pollReq, pollAnswer, pollNoAnswer;
    logic [5:0] origin = 6'h00;
    logic [5:0] lower = 6'h00;
    logic [5:0] upper = 6'h00;
    logic [1:0] estop = 2'h0;
    logic pwrFault = 1'h0;
    logic bootDone = 1'h0;
    logic pciErr = 1'h0;
    logic canFrame = 1'h0;
    logic canFull = 1'h0;
    logic canRun = 1'h0;
    logic [15:0] present = 16'h0005;
    logic [3:0] ansDelay = 4'h1;
    logic [3:0] pollId;
    logic nodeErr;
    logic ledCan, ledRs485, hostLed, ledBoot, ledError;
    logic [4:0] leds;
    logic [31:0] rdLast;
    logic [19:0] inExp;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;

    assign leds = {ledError, ledBoot, hostLed, ledRs485, ledCan};

    mcsw_watchdog #(.BLINK_CYC(4)) mcsw_watchdog_inst (
        .clk(clk), .resetn(resetn), .avs_address(busAddr),
        .avs_read(busRead), .avs_write(busWrite), .avs_writedata(busWdata),
        .avs_byteenable(4'hF), .avs_readdata(busRdata),
        .avs_waitrequest(busWait), .irq(irq), .jointOriginSwitch(origin),
        .jointLowerLimitSwitch(lower), .jointUpperLimitSwitch(upper),
        .estopSwitch(estop), .powerFault(pwrFault),
        .powerEnable(powerEnable), .bootDone(bootDone),
        .pciCommError(pciErr), .canFrame(canFrame),
        .canBufferFull(canFull), .pollReq(pollReq), .pollId(pollId),
        .pollAnswer(pollAnswer), .pollNoAnswer(pollNoAnswer),
        .ledCan(ledCan), .ledRs485(ledRs485), .host_activity_led(hostLed),
        .ledBoot(ledBoot), .ledError(ledError));

    mcsw_node_model mcsw_node_model_inst (
        .clk(clk), .resetn(resetn), .present(present),
        .ansDelay(ansDelay), .pollReq(pollReq), .pollId(pollId),
        .pollAnswer(pollAnswer), .pollNoAnswer(pollNoAnswer),
        .nodeError(nodeErr));

    initial forever #4 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        canFrame <= canRun && (cyc % 4 == 0);
        if (cyc == 6000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    // Waitrequest and read data are taken at the rising edge, with the
    // values that stood just before it, as the slave sees the request.
    task automatic bus_go(input logic [5:0] a, input logic w,
                          input logic [31:0] v);
        int k;
        k = 0;
        busAddr <= a;
        busRead <= !w;
        busWrite <= w;
        busWdata <= v;
        @(posedge clk);
        while (busWait !== 1'h0 && k < 64)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 64)
            chk("waitrequest", 32'h0, 32'h1);
        rdLast = busRdata;
        busRead <= 1'h0;
        busWrite <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
                          input string nm);
        bus_go(a, 1'h0, 32'h0);
        chk(nm, e, rdLast);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
    endtask

    // A steady LED must neither toggle nor sit at the wrong level.
    task automatic led_chk(input string nm, input int i, input logic blink,
                           input logic lvl);
        logic [4:0] prev;
        int tog;
        tog = 0;
        cyc_wait(2);
        @(negedge clk);
        prev = leds;
        repeat (24)
        begin
            @(negedge clk);
            if (leds[i] !== prev[i])
                tog++;
            prev = leds;
        end
        @(posedge clk);
        if (blink)
            chk(nm, 32'h1, 32'(tog > 0));
        else
            chk(nm, {31'h0, lvl}, {31'h0, prev[i]} | (32'(tog) << 1));
    endtask

    task automatic test_end(input string nm);
        $display("test %s finished", nm);
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        led_chk("ledRs485 scan", 1, 1'h1, 1'h0);
        led_chk("ledBoot off", 3, 1'h0, 1'h0);
        led_chk("hostLed off", 2, 1'h0, 1'h0);
        led_chk("ledCan off", 0, 1'h0, 1'h0);
        led_chk("ledError off", 4, 1'h0, 1'h0);
        chk1("powerEnable reset", 1'h0, powerEnable);
        rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
        rd_chk(OFS_TIMEOUT, TIMEOUT_RST_NS, "timeout reset");
        bus_go(6'h20, 1'h1, 32'hFFFF_FFFF);
        rd_chk(6'h20, 32'h0, "unmapped");
        test_end("reset");
        for (int p = 0; p < 2; p++)
        begin
            origin <= p ? 6'h15 : 6'h2A;
            lower <= p ? 6'h0F : 6'h30;
            upper <= p ? 6'h33 : 6'h0C;
            estop <= p ? 2'h1 : 2'h2;
            cyc_wait(4);
            inExp = {estop, upper, lower, origin};
            rd_chk(OFS_INPUTS, {12'h0, inExp}, "in");
            rd_chk(OFS_INPUTS_N, {12'h0, ~inExp}, "in n");
        end
        test_end("inputs");
        cyc_wait(150);
        rd_chk(OFS_NODES, 32'h5, "nodes found");
        led_chk("ledRs485 up", 1, 1'h0, 1'h1);
        present <= 16'h0001;
        ansDelay <= 4'h6;
        cyc_wait(800);
        rd_chk(OFS_NODES, 32'h1, "nodes left");
        led_chk("ledRs485 drop", 1, 1'h0, 1'h0);
        present <= 16'h0003;
        bus_go(OFS_CTRL, 1'h1, 32'h1 << CTRL_RESCAN);
        cyc_wait(250);
        rd_chk(OFS_NODES, 32'h3, "nodes rescan");
        led_chk("ledRs485 rescan", 1, 1'h0, 1'h1);
        test_end("nodes");
        bootDone <= 1'h1;
        led_chk("ledBoot on", 3, 1'h0, 1'h1);
        canRun <= 1'h1;
        led_chk("ledCan blink", 0, 1'h1, 1'h0);
        canRun <= 1'h0;
        canFull <= 1'h1;
        led_chk("ledCan full", 0, 1'h0, 1'h1);
        canFull <= 1'h0;
        cyc_wait(12);
        led_chk("ledCan idle", 0, 1'h0, 1'h0);
        pciErr <= 1'h1;
        led_chk("ledError pci", 4, 1'h1, 1'h0);
        pciErr <= 1'h0;
        bus_go(OFS_CTRL, 1'h1, 32'h1 << CTRL_HOST_RUN);
        led_chk("hostLed run", 2, 1'h1, 1'h0);
        test_end("indicators");
        bus_go(OFS_CTRL, 1'h1, 32'h2);
        cyc_wait(40);
        chk1("power wd off", 1'h1, powerEnable);
        bus_go(OFS_TIMEOUT, 1'h1, 32'h0000_0050);
        bus_go(OFS_IRQ_STAT, 1'h0, 32'h0);
        bus_go(OFS_IRQ_MASK, 1'h1, 32'h1);
        bus_go(OFS_CTRL, 1'h1, 32'h3);
        repeat (15) bus_go(OFS_INPUTS, 1'h0, 32'h0);
        chk1("power kept", 1'h1, powerEnable);
        cyc_wait(30);
        chk1("power expired", 1'h0, powerEnable);
        chk1("irq expired", 1'h1, irq);
        led_chk("ledError wd", 4, 1'h0, 1'h1);
        bus_go(OFS_STATUS, 1'h0, 32'h0);
        chk("status", 32'h1, rdLast & 32'h7);
        bus_go(OFS_IRQ_STAT, 1'h0, 32'h0);
        chk("irq stat", 32'h1, rdLast & 32'h1);
        chk1("irq cleared", 1'h0, irq);
        bus_go(OFS_INPUTS, 1'h0, 32'h0);
        bus_go(OFS_CTRL, 1'h1, 32'h2);
        bus_go(OFS_STATUS, 1'h0, 32'h0);
        chk("expiry held", 32'h1, rdLast & 32'h1);
        bus_go(OFS_CTRL, 1'h1, 32'h3);
        bus_go(OFS_CTRL, 1'h1, 32'h2);
        cyc_wait(20);
        chk1("power back", 1'h1, powerEnable);
        pwrFault <= 1'h1;
        cyc_wait(5);
        chk1("power fault", 1'h0, powerEnable);
        chk1("irq masked", 1'h0, irq);
        bus_go(OFS_IRQ_STAT, 1'h0, 32'h0);
        chk("fault event", 32'h2, rdLast & 32'h2);
        pwrFault <= 1'h0;
        cyc_wait(5);
        chk1("power restored", 1'h1, powerEnable);
        chk1("chain fed", 1'h0, nodeErr);
        test_end("watchdog");
        close_out();
    end
endmodule
